// *** src/link_cfg_pkg.sv ***
package link_cfg_pkg;
  // Register map, 16-bit addresses
  localparam logic [15:0] LANE_RATE_OFS  = 16'h056e;
  localparam logic [15:0] PLL_STATUS_OFS = 16'h056f;
  localparam logic [15:0] QUICK_CFG_OFS  = 16'h0570;
  localparam logic [15:0] LINK_PWR_OFS   = 16'h0571;
  localparam int          PLL_LOCK_BIT   = 7;
  localparam int          PWR_DOWN_BIT   = 0;
  // Reset values
  localparam logic [7:0]  LANE_RATE_RST  = 8'h00;
  localparam logic [7:0]  QUICK_CFG_RST  = 8'h48;
  localparam logic        PWR_DOWN_RST   = 1'b0;
  // Latencies in sample clocks, one sample clock per i_clk
  localparam int          CONV_LAT       = 31;
  localparam int          FRM_LAT_HALF   = 23;
  localparam int          FRM_LAT_ONE    = 14;
  localparam int          FRM_LAT_TWO    = 7;
  localparam int          FRM_DLY_DEPTH  = FRM_LAT_HALF - 1;
  localparam int          SLOT_BITS      = 8;
  localparam int          FIFO_DEPTH     = 4;

  typedef enum logic [2:0] {
    RATIO_HALF = 3'b001,
    RATIO_ONE  = 3'b010,
    RATIO_TWO  = 3'b100
  } ratio_e;

  typedef struct packed {
    logic [SLOT_BITS-1:0] a;
    logic [SLOT_BITS-1:0] b;
    logic [SLOT_BITS-1:0] c;
    logic [SLOT_BITS-1:0] d;
  } sample_s;

  typedef struct packed {
    logic    v;
    sample_s s;
  } tagged_s;

  typedef struct packed {
    logic        v0;
    logic        v1;
    logic [15:0] d0;
    logic [15:0] d1;
  } lane_word_s;

  typedef struct packed {
    logic       valid;
    logic [1:0] lanes;
    logic [1:0] convs;
    logic [4:0] octets;
    ratio_e     ratio;
  } link_cfg_s;

  // Quick-configuration code to link shape; valid low for unsupported codes
  function automatic link_cfg_s quick_decode(input logic [7:0] code);
    link_cfg_s c;
    c = '{valid: 1'b1, lanes: 2'd2, convs: 2'd2, octets: 5'd2, ratio: RATIO_ONE};
    case (code)
      8'h00: c = '{1'b1, 2'd1, 2'd1, 5'd1, RATIO_ONE};
      8'h01: c = '{1'b1, 2'd1, 2'd1, 5'd2, RATIO_ONE};
      8'h40: c = '{1'b1, 2'd2, 2'd1, 5'd1, RATIO_HALF};
      8'h41: c = '{1'b1, 2'd2, 2'd1, 5'd2, RATIO_HALF};
      8'h42: c = '{1'b1, 2'd2, 2'd1, 5'd4, RATIO_HALF};
      8'h09: c = '{1'b1, 2'd1, 2'd2, 5'd2, RATIO_TWO};
      8'h48: c = '{1'b1, 2'd2, 2'd2, 5'd2, RATIO_ONE};
      8'h49: c = '{1'b1, 2'd2, 2'd2, 5'd2, RATIO_ONE};
      default: c.valid = 1'b0;
    endcase
    return c;
  endfunction

  // Framing-stage latency for a converters-per-lane ratio
  function automatic int frame_latency(input ratio_e r);
    case (r)
      RATIO_HALF: return FRM_LAT_HALF;
      RATIO_TWO:  return FRM_LAT_TWO;
      default:    return FRM_LAT_ONE;
    endcase
  endfunction
endpackage

// *** src/serial_link_tx_config.sv ***
`timescale 1ns/1ps

// Show-ahead FIFO; depth must be a power of two so pointers wrap freely
module sample_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 4
) (
  input  wire logic         i_clk,
  input  wire logic         i_sys_rst,
  input  wire logic [W-1:0] i_in_data,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  output logic [W-1:0]      o_out_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [AW:0]   cnt_reg, cnt_next;
  logic          push, pop, rdy_reg, rdy_next;

  // Ready is registered so that an upstream port fed by it comes from a flop
  assign o_in_ready  = rdy_reg;
  assign o_out_valid = (cnt_reg != '0);
  assign o_out_data  = mem[rp_reg];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  // Pointer and occupancy update
  always_comb begin
    wp_next  = push ? wp_reg + 1'b1 : wp_reg;
    rp_next  = pop ? rp_reg + 1'b1 : rp_reg;
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    rdy_next = (cnt_next != (AW+1)'(DEPTH));
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
      rdy_reg <= 1'b1;
    end else begin
      wp_reg  <= wp_next;
      rp_reg  <= rp_next;
      cnt_reg <= cnt_next;
      rdy_reg <= rdy_next;
    end
  end

  // Storage needs no reset, occupancy guards it
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wp_reg] <= i_in_data;
    end
  end
endmodule

module serial_link_tx_config
  import link_cfg_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [15:0] i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  output logic [7:0]       o_reg_rdata,
  input  wire logic        i_pll_lock,
  input  wire sample_s     i_smp,
  input  wire logic        i_smp_valid,
  output logic             o_smp_ready,
  output logic [15:0]      o_lane_pair_one_lane0,
  output logic [15:0]      o_lane_pair_one_lane1,
  output logic [15:0]      o_lane_pair_two_lane0,
  output logic [15:0]      o_lane_pair_two_lane1,
  output logic [3:0]       o_lane_valid
);
  logic [7:0] lane_rate_reg, lane_rate_next, quick_reg, quick_next, rdata_reg, rdata_next;
  logic       pd_reg, pd_next, lock_s1, lock_s2, apply, pop, fifo_v, fifo_rdy;
  link_cfg_s  act_reg, act_next, wr_code;
  sample_s    fifo_d;
  tagged_s    cdl_reg [CONV_LAT];
  tagged_s    cdl_next [CONV_LAT];
  lane_word_s out_reg [2];

  // Samples wait here while the link is down; a full FIFO stalls the source
  sample_fifo #(.W($bits(sample_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk       (i_clk),
    .i_sys_rst   (i_sys_rst),
    .i_in_data   (i_smp),
    .i_in_valid  (i_smp_valid),
    .o_in_ready  (fifo_rdy),
    .o_out_data  (fifo_d),
    .o_out_valid (fifo_v),
    .i_out_ready (!pd_reg)
  );
  assign pop = fifo_v && !pd_reg;
  assign wr_code = quick_decode(i_reg_wdata);

  // Register writes; illegal quick codes are dropped
  always_comb begin
    lane_rate_next = lane_rate_reg;
    quick_next     = quick_reg;
    pd_next        = pd_reg;
    if (i_reg_wr) begin
      if (i_reg_addr == LANE_RATE_OFS) begin
        lane_rate_next = i_reg_wdata;
      end else if (i_reg_addr == QUICK_CFG_OFS && wr_code.valid) begin
        quick_next = i_reg_wdata;
      end else if (i_reg_addr == LINK_PWR_OFS) begin
        pd_next = i_reg_wdata[PWR_DOWN_BIT];
      end
    end
    apply    = pd_reg && !pd_next;
    act_next = apply ? quick_decode(quick_next) : act_reg;
  end

  // Read mux, registered so the data port comes from a flop
  always_comb begin
    rdata_next = rdata_reg;
    if (i_reg_rd) begin
      if (i_reg_addr == LANE_RATE_OFS) begin
        rdata_next = lane_rate_reg;
      end else if (i_reg_addr == PLL_STATUS_OFS) begin
        rdata_next = 8'h00;
        rdata_next[PLL_LOCK_BIT] = lock_s2;
      end else if (i_reg_addr == QUICK_CFG_OFS) begin
        rdata_next = quick_reg;
      end else if (i_reg_addr == LINK_PWR_OFS) begin
        rdata_next = {7'h00, pd_reg};
      end else begin
        rdata_next = 8'h00;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      lane_rate_reg <= LANE_RATE_RST;
      quick_reg     <= QUICK_CFG_RST;
      pd_reg        <= PWR_DOWN_RST;
      act_reg       <= quick_decode(QUICK_CFG_RST);
      rdata_reg     <= 8'h00;
      lock_s1       <= 1'b0;
      lock_s2       <= 1'b0;
    end else begin
      lane_rate_reg <= lane_rate_next;
      quick_reg     <= quick_next;
      pd_reg        <= pd_next;
      act_reg       <= act_next;
      rdata_reg     <= rdata_next;
      lock_s1       <= i_pll_lock;
      lock_s2       <= lock_s1;
    end
  end

  always_comb begin
    cdl_next[0] = '{v: pop, s: fifo_d};
    for (int k = 1; k < CONV_LAT; k++) begin
      cdl_next[k] = cdl_reg[k-1];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      for (int k = 0; k < CONV_LAT; k++) cdl_reg[k] <= '0;
    end else begin
      for (int k = 0; k < CONV_LAT; k++) cdl_reg[k] <= cdl_next[k];
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_link
    logic [7:0]  vc0, vc1, h0_reg, h0_next, h1_reg, h1_next;
    logic [1:0]  ph_reg, ph_next;
    lane_word_s  wn, out_next;
    lane_word_s  fdl_reg [FRM_DLY_DEPTH];
    lane_word_s  fdl_next [FRM_DLY_DEPTH];
    assign vc0 = (g == 0) ? cdl_reg[CONV_LAT-1].s.a : cdl_reg[CONV_LAT-1].s.c;
    assign vc1 = (g == 0) ? cdl_reg[CONV_LAT-1].s.b : cdl_reg[CONV_LAT-1].s.d;

    // octets per lane per sample set by M over L; earliest octet in upper byte
    always_comb begin
      ph_next = ph_reg;
      h0_next = h0_reg;
      h1_next = h1_reg;
      wn      = '0;
      if (apply) begin
        ph_next = 2'd0;
      end else if (cdl_reg[CONV_LAT-1].v) begin
        case (act_reg.ratio)
          RATIO_TWO: begin
            wn.v0 = 1'b1;
            wn.d0 = {vc0, vc1};
          end
          RATIO_ONE: begin
            ph_next = {1'b0, ~ph_reg[0]};
            if (!ph_reg[0]) begin
              h0_next = vc0;
              h1_next = vc1;
            end else begin
              wn.v0 = 1'b1;
              wn.d0 = {h0_reg, vc0};
              wn.v1 = (act_reg.convs == 2'd2);
              wn.d1 = {h1_reg, vc1};
            end
          end
          default: begin
            ph_next = ph_reg + 2'd1;
            if (!ph_reg[0]) begin
              h0_next = vc0;
            end
            wn.v0 = (ph_reg == 2'd1);
            wn.v1 = (ph_reg == 2'd3);
            wn.d0 = {h0_reg, vc0};
            wn.d1 = {h0_reg, vc0};
          end
        endcase
      end
    end

    always_comb begin
      fdl_next[0] = wn;
      for (int k = 1; k < FRM_DLY_DEPTH; k++) begin
        fdl_next[k] = fdl_reg[k-1];
      end
      out_next = pd_reg ? '0 : fdl_reg[frame_latency(act_reg.ratio) - 2];
    end

    always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
        ph_reg     <= 2'd0;
        h0_reg     <= 8'h00;
        h1_reg     <= 8'h00;
        out_reg[g] <= '0;
        for (int k = 0; k < FRM_DLY_DEPTH; k++) fdl_reg[k] <= '0;
      end else begin
        ph_reg     <= ph_next;
        h0_reg     <= h0_next;
        h1_reg     <= h1_next;
        out_reg[g] <= out_next;
        for (int k = 0; k < FRM_DLY_DEPTH; k++) fdl_reg[k] <= fdl_next[k];
      end
    end
  end

  // slots pass through 8 bits wide, untouched
  assign o_lane_pair_one_lane0 = out_reg[0].d0;
  assign o_lane_pair_one_lane1 = out_reg[0].d1;
  assign o_lane_pair_two_lane0 = out_reg[1].d0;
  assign o_lane_pair_two_lane1 = out_reg[1].d1;
  assign o_lane_valid          = {out_reg[1].v1, out_reg[1].v0, out_reg[0].v1, out_reg[0].v0};
  assign o_reg_rdata           = rdata_reg;
  assign o_smp_ready           = fifo_rdy;

  a_down_quiet: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    pd_reg |=> (o_lane_valid == 4'h0)) else $error("lanes active while powered down");
  a_cfg_apply: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $changed(act_reg) |-> ($past(pd_reg) && !pd_reg)) else $error("config changed outside power-up");
  a_bad_code: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_reg_wr && i_reg_addr == QUICK_CFG_OFS && !wr_code.valid) |=> $stable(quick_reg))
    else $error("illegal quick code stored");
  a_code_48: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (quick_reg == 8'h48 && $past(pd_reg) && !pd_reg) |-> (act_reg.lanes == 2'd2 && act_reg.convs == 2'd2
    && act_reg.octets == 5'd2)) else $error("code 48 shape wrong");
  a_conv_delay: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    pop |-> ##31 (cdl_reg[CONV_LAT-1].v && cdl_reg[CONV_LAT-1].s == $past(fifo_d, 31)))
    else $error("converter delay not 31");
  a_ratio_two: assert property (@(posedge i_clk) disable iff (i_sys_rst || pd_reg)
    (pop && act_reg.ratio == RATIO_TWO) |-> ##38 (o_lane_valid[0]
    && o_lane_pair_one_lane0 == {$past(fifo_d.a, 38), $past(fifo_d.b, 38)})) else $error("ratio 2 latency or map");
  a_ratio_half: assert property (@(posedge i_clk) disable iff (i_sys_rst || pd_reg)
    (pop && act_reg.ratio == RATIO_HALF) ##31 (g_link[1].ph_reg == 2'd3) |-> ##23 (o_lane_valid[3]
    && o_lane_pair_two_lane1[7:0] == $past(fifo_d.c, 54))) else $error("ratio 0.5 latency or map");
  a_pll_read: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_reg_rd && i_reg_addr == PLL_STATUS_OFS) |=> (o_reg_rdata[7] == $past(lock_s2) && o_reg_rdata[6:0] == 7'h00))
    else $error("pll lock readback wrong");
endmodule

// *** testbench/link_rx_model.sv ***
`timescale 1ns/1ps
// Far-end receiver: keeps the first word, its arrival time and a word count
module link_rx_model (
  input  wire logic            i_clk,
  input  wire logic            i_clear,
  input  wire logic [15:0]     i_lane0,
  input  wire logic [15:0]     i_lane1,
  input  wire logic [15:0]     i_lane2,
  input  wire logic [15:0]     i_lane3,
  input  wire logic [3:0]      i_lane_valid,
  output logic [3:0][15:0]     o_first,
  output logic [3:0][15:0]     o_when,
  output logic [3:0]           o_got,
  output logic [7:0]           o_count
);
  logic [15:0]       cyc_reg;
  logic [3:0][15:0]  lanes;

  assign lanes = {i_lane3, i_lane2, i_lane1, i_lane0};

  // Time base restarts with each capture window
  always_ff @(posedge i_clk) begin
    cyc_reg <= i_clear ? 16'h0000 : cyc_reg + 16'h0001;
  end

  always_ff @(posedge i_clk) begin
    if (i_clear) begin
      o_got   <= 4'h0;
      o_count <= 8'h00;
    end else begin
      for (int k = 0; k < 4; k++) begin
        if (i_lane_valid[k] && !o_got[k]) begin
          o_got[k]   <= 1'b1;
          o_first[k] <= lanes[k];
          o_when[k]  <= cyc_reg;
        end
      end
      if (i_lane_valid[0]) o_count <= o_count + 8'h01; // Only lane 0 counted
    end
  end
endmodule

// *** testbench/test_serial_link_tx_config.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module test_serial_link_tx_config;
  import link_cfg_pkg::*;
  logic             clk = 1'b0;
  logic             sys_rst, wr, rd, pll_lock, smp_valid, smp_ready, clear;
  logic [15:0]      addr;
  logic [7:0]       wdata, rdata;
  sample_s          smp;
  logic [15:0]      l0, l1, l2, l3;
  logic [3:0]       lane_valid, got;
  logic [3:0][15:0] first, when_c;
  logic [7:0]       count;
  int               checks = 0;
  int               error_cnt = 0;

  serial_link_tx_config dut (.i_clk(clk), .i_sys_rst(sys_rst), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_pll_lock(pll_lock), .i_smp(smp), .i_smp_valid(smp_valid),
    .o_smp_ready(smp_ready), .o_lane_pair_one_lane0(l0), .o_lane_pair_one_lane1(l1), .o_lane_pair_two_lane0(l2),
    .o_lane_pair_two_lane1(l3), .o_lane_valid(lane_valid));
  link_rx_model rx (.i_clk(clk), .i_clear(clear), .i_lane0(l0), .i_lane1(l1), .i_lane2(l2), .i_lane3(l3),
    .i_lane_valid(lane_valid), .o_first(first), .o_when(when_c), .o_got(got), .o_count(count));

  // 200 MHz sample clock
  always #2.5 clk = ~clk;

  // Sample i carries 1i, 2i, 3i, 4i on channels a to d
  function automatic sample_s smp_of(input int i);
    smp_of = {8'h10 + 8'(i), 8'h20 + 8'(i), 8'h30 + 8'(i), 8'h40 + 8'(i)};
  endfunction

  task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Data is picked up one edge late; it holds until the next read anyway
  task automatic reg_chk(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    #1 `CHK(rdata, e)
  endtask

  // only table codes, no multiframe length driven
  task automatic cfg(input logic [7:0] code);
    reg_wr(LINK_PWR_OFS, 8'h01);
    reg_wr(QUICK_CFG_OFS, code);
    reg_wr(LINK_PWR_OFS, 8'h00);
  endtask

  // Offer samples back to back; ready is judged before each edge
  task automatic push(input int n, input int lim, output int acc);
    bit r;
    acc = 0;
    @(posedge clk);
    smp_valid <= 1'b1;
    smp       <= smp_of(0);
    clear     <= 1'b1;
    for (int i = 0; i < lim && acc < n; i++) begin
      @(negedge clk);
      r = smp_ready;
      @(posedge clk);
      clear <= 1'b0;
      if (r) acc++;
      smp       <= smp_of(acc);
      smp_valid <= (acc < n) && (i < lim - 1); // Dropped on the last edge either way
    end
  endtask

  task automatic wait_got(input int k);
    for (int i = 0; i < 300 && got[k] !== 1'b1; i++) @(posedge clk);
    if (got[k] !== 1'b1) begin
      error_cnt++;
      conclude();
    end
  endtask

  task automatic t_regs();
    logic [7:0] rates [4] = '{8'h30, 8'h00, 8'h50, 8'h10};
    reg_chk(LANE_RATE_OFS, 8'h00);
    reg_chk(QUICK_CFG_OFS, 8'h48);
    reg_chk(16'h0100, 8'h00);
    reg_chk(LINK_PWR_OFS, 8'h00);
    foreach (rates[i]) begin
      reg_wr(LANE_RATE_OFS, rates[i]);
      reg_chk(LANE_RATE_OFS, rates[i]);
    end
    reg_wr(QUICK_CFG_OFS, 8'h55);
    reg_chk(QUICK_CFG_OFS, 8'h48);
    pll_lock <= 1'b1;
    reg_wr(PLL_STATUS_OFS, 8'h00);
    reg_chk(PLL_STATUS_OFS, 8'h80);
    pll_lock <= 1'b0;
    repeat (4) @(posedge clk);
    reg_chk(PLL_STATUS_OFS, 8'h00);
    $display("test regs done");
  endtask

  // Link down: lanes idle, FIFO refuses after four, drains at power-up
  task automatic t_fill();
    int acc;
    cfg(8'h09);
    reg_wr(LINK_PWR_OFS, 8'h01);
    repeat (3) @(posedge clk);
    push(6, 12, acc);
    `CHK(acc, 4)
    #1 `CHK(smp_ready, 1'b0)
    `CHK({l0, l1, l2, l3, lane_valid}, 68'h0)
    reg_chk(LINK_PWR_OFS, 8'h01);
    reg_wr(LINK_PWR_OFS, 8'h00);
    wait_got(0);
    repeat (8) @(posedge clk);
    `CHK(count, 8'h04)
    `CHK(first[0], 16'h1020)
    $display("test fill done");
  endtask

  // Every quick code: channel mapping and total latency
  task automatic t_codes();
    logic [7:0] codes [8] = '{8'h00, 8'h01, 8'h40, 8'h41, 8'h42, 8'h09, 8'h48, 8'h49};
    int rat [8] = '{1, 1, 0, 0, 0, 2, 1, 1};
    int acc;
    int f;
    foreach (codes[i]) begin
      f = (rat[i] == 0) ? FRM_LAT_HALF : (rat[i] == 1) ? FRM_LAT_ONE : FRM_LAT_TWO;
      cfg(codes[i]);
      push(4, 20, acc);
      wait_got(0);
      repeat (6) @(posedge clk);
      // Model time counts from acceptance; pairing modes finish on the second sample
      `CHK(when_c[0], 16'(CONV_LAT + f + (rat[i] == 2 ? 0 : 1)))
      `CHK(first[0], (rat[i] == 2) ? 16'h1020 : 16'h1011)
      `CHK(first[2], (rat[i] == 2) ? 16'h3040 : 16'h3031)
      if (rat[i] == 0) `CHK(first[1], 16'h1213)
      if (rat[i] == 0) `CHK(first[3], 16'h3233)
      if (rat[i] == 1 && i > 5) `CHK(first[1], 16'h2021)
      if (rat[i] == 1 && i > 5) `CHK(first[3], 16'h4041)
    end
    $display("test codes done");
  endtask

  task automatic conclude();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Reset for two cycles, then run the scenarios
  initial begin
    sys_rst   = 1'b1;
    wr        = 1'b0;
    rd        = 1'b0;
    addr      = 16'h0000;
    wdata     = 8'h00;
    pll_lock  = 1'b0;
    smp       = '0;
    smp_valid = 1'b0;
    clear     = 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs();
    t_fill();
    t_codes();
    conclude();
  end
endmodule
